// ### common/udp_pkg.sv
`default_nettype none
package udp_pkg;
  // Bus decode
  localparam logic [19:0] ADDR_HI_ZERO = 20'h00000;
  localparam logic [1:0]  BDT_REGION   = 2'h0;
  localparam logic [11:0] CFG_OFS      = 12'h400;
  localparam logic [11:0] TSTAT_OFS    = 12'h404;
  localparam logic [11:0] SFLAG_OFS    = 12'h408;
  localparam logic [11:0] SEN_OFS      = 12'h40C;
  localparam logic [11:0] EFLAG_OFS    = 12'h410;
  localparam logic [11:0] EEN_OFS      = 12'h414;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HRESP_OKAY    = 2'h0;
  localparam logic [31:0] RDATA_ZERO    = 32'h00000000;
  // Descriptor fields within one descriptor's four words
  localparam logic [1:0] FLD_STAT = 2'h0;
  localparam logic [1:0] FLD_CNT  = 2'h1;
  localparam logic [1:0] FLD_ADRL = 2'h2;
  localparam logic [1:0] FLD_ADRH = 2'h3;
  localparam int unsigned BD_NUM  = 64;
  localparam int unsigned PTR_NUM = 32;
  // Descriptor status bits
  localparam int unsigned OWN_BIT    = 7;
  localparam int unsigned TOGGLE_BIT = 6;
  localparam int unsigned KEEP_BIT   = 5;
  localparam int unsigned STALL_BIT  = 2;
  localparam int unsigned CFGF_HI    = 5;
  localparam int unsigned CFGF_LO    = 2;
  localparam logic [3:0]  PID_SETUP  = 4'hD;
  // Config register
  localparam int unsigned CFG_ENABLE_BIT  = 3;
  localparam int unsigned CFG_PTR_CLR_BIT = 4;
  localparam logic [7:0]  CFG_RST         = 8'h00;
  // Status flag bits
  localparam int unsigned SF_SOF   = 6;
  localparam int unsigned SF_STALL = 5;
  localparam int unsigned SF_IDLE  = 4;
  localparam int unsigned SF_TRN   = 3;
  localparam int unsigned SF_ACTV  = 2;
  localparam int unsigned SF_ERR   = 1;
  localparam int unsigned SF_URST  = 0;
  localparam logic [7:0]  SFLAG_WMASK = 8'h75;
  localparam logic [7:0]  FLAG_RST    = 8'h00;
  // Transfer status FIFO
  localparam int unsigned FIFO_DEPTH = 4;
  localparam logic [2:0]  FIFO_FULL  = 3'h4;
  localparam logic [2:0]  FIFO_EMPTY = 3'h0;

  typedef enum logic [1:0] {
    PP_NONE    = 2'b00,
    PP_EP0_OUT = 2'b01,
    PP_ALL     = 2'b10,
    PP_RSVD    = 2'b11
  } udp_mode_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_READ = 1'b1
  } udp_bus_t;
endpackage : udp_pkg
`default_nettype wire

// ### hdl/udp_core.sv
`timescale 1ns/100ps
`default_nettype none
module udp_core
  import udp_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic      [1:0]  hresp_o,
  // Serial engine lookup and completion
  input  wire logic [3:0]  eng_ep_i,
  input  wire logic        eng_dir_in_i,
  input  wire logic        eng_done_i,
  input  wire logic [3:0]  eng_pid_i,
  input  wire logic [9:0]  eng_count_i,
  output logic             eng_ready_o,
  output logic      [5:0]  eng_bd_index_o,
  output logic             eng_bd_owned_o,
  output logic             eng_bd_toggle_o,
  output logic      [3:0]  eng_bd_cfg_o,
  output logic      [9:0]  eng_bd_count_o,
  output logic      [15:0] eng_bd_addr_o,
  // Engine events
  input  wire logic        ev_sof_i,
  input  wire logic        ev_idle_i,
  input  wire logic        ev_actv_i,
  input  wire logic        ev_urst_i,
  input  wire logic [7:0]  ev_err_i,
  // Interrupt request
  output logic             usb_irq_request_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Descriptor mapping
  function automatic logic [5:0] bd_map(input udp_mode_t m, input logic [3:0] ep,
                                        input logic dir, input logic pp);
    logic [5:0] n;
    n = {2'h0, ep};
    case (m)
      PP_EP0_OUT:
        if (ep == 4'h0)
          bd_map = dir ? 6'h02 : {5'h00, pp};
        else
          bd_map = 6'((n << 1) + 6'h01 + {5'h00, dir});
      PP_ALL:
        bd_map = {ep, dir, pp};
      default:
        bd_map = {1'b0, ep, dir};
    endcase
  endfunction : bd_map

  function automatic logic is_pp(input udp_mode_t m, input logic [3:0] ep, input logic dir);
    case (m)
      PP_EP0_OUT: is_pp = (ep == 4'h0) && !dir;
      PP_ALL:     is_pp = 1'b1;
      default:    is_pp = 1'b0;
    endcase
  endfunction : is_pp

  //////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0]  bd_stat [BD_NUM];
  logic [7:0]  bd_cnt  [BD_NUM];
  logic [7:0]  bd_adrl [BD_NUM];
  logic [7:0]  bd_adrh [BD_NUM];
  logic        ptr     [PTR_NUM];
  logic [7:0]  cfg;
  logic [7:0]  sflag;
  logic [7:0]  sen;
  logic [7:0]  eflag;
  logic [7:0]  een;
  logic [5:0]  tfifo   [FIFO_DEPTH];
  logic [1:0]  fifo_wp;
  logic [1:0]  fifo_rp;
  logic [2:0]  fifo_cnt;
  udp_bus_t    bus_state;
  logic        wr_pend;
  logic [11:0] acc_addr;

  udp_mode_t   mode;
  logic        mod_en;
  logic [4:0]  ptr_sel;
  logic        cur_pp;
  logic [5:0]  idx_c;
  logic        owned_c;
  logic        take_c;
  logic        stall_hit_c;
  logic        complete_c;
  logic        addr_ok;
  logic        bus_go;
  logic        wr_bdt;
  logic        trn_clr;
  logic        err_sum;
  logic [7:0]  status_view;
  logic [31:0] next_rdata;
  logic [5:0]  acc_bd;

  assign mode    = udp_mode_t'(cfg[1:0]);
  assign mod_en  = cfg[CFG_ENABLE_BIT];
  assign ptr_sel = {eng_ep_i, eng_dir_in_i};
  assign cur_pp  = ptr[ptr_sel];
  assign idx_c   = bd_map(mode, eng_ep_i, eng_dir_in_i, cur_pp);
  assign owned_c = bd_stat[idx_c][OWN_BIT];
  assign take_c  = eng_done_i && eng_ready_o && mod_en && owned_c;
  // A stalled descriptor stays put; only a SETUP token releases it
  assign stall_hit_c = take_c && bd_stat[idx_c][STALL_BIT] && (eng_pid_i != PID_SETUP);
  assign complete_c  = take_c && !bd_stat[idx_c][KEEP_BIT] && !stall_hit_c;
  assign acc_bd  = acc_addr[9:4];

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: reads take one wait state so they see the previous write
  assign addr_ok = (haddr_i[31:12] == ADDR_HI_ZERO);
  assign bus_go  = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
  assign wr_bdt  = wr_pend && (acc_addr[11:10] == BDT_REGION);
  assign trn_clr = wr_pend && (acc_addr == SFLAG_OFS) && !hwdata_i[SF_TRN]
                   && (fifo_cnt != FIFO_EMPTY);

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      bus_state   <= BUS_IDLE;
      wr_pend     <= 1'b0;
      acc_addr    <= 12'h000;
      hreadyout_o <= 1'b1;
      hrdata_o    <= RDATA_ZERO;
    end
    else
    begin
      wr_pend <= 1'b0;
      case (bus_state)
        BUS_IDLE:
          if (bus_go)
          begin
            acc_addr <= addr_ok ? haddr_i[11:0] : 12'hFFC;
            if (hwrite_i)
              wr_pend <= 1'b1;
            else
            begin
              bus_state   <= BUS_READ;
              hreadyout_o <= 1'b0;
            end
          end
        BUS_READ:
        begin
          hrdata_o    <= next_rdata;
          hreadyout_o <= 1'b1;
          bus_state   <= BUS_IDLE;
        end
        default:
          bus_state <= BUS_IDLE;
      endcase
    end
  end

  assign hresp_o = HRESP_OKAY;

  always_comb
  begin
    next_rdata = RDATA_ZERO;
    if (acc_addr[11:10] == BDT_REGION)
      case (acc_addr[3:2])
        FLD_STAT: next_rdata[7:0] = bd_stat[acc_bd];
        FLD_CNT:  next_rdata[7:0] = bd_cnt[acc_bd];
        FLD_ADRL: next_rdata[7:0] = bd_adrl[acc_bd];
        default:  next_rdata[7:0] = bd_adrh[acc_bd];
      endcase
    else
      case (acc_addr)
        CFG_OFS:   next_rdata[7:0] = cfg;
        TSTAT_OFS: next_rdata[7:0] = {1'b0, tfifo[fifo_rp], 1'b0};
        SFLAG_OFS: next_rdata[7:0] = status_view;
        SEN_OFS:   next_rdata[7:0] = sen;
        EFLAG_OFS: next_rdata[7:0] = eflag;
        EEN_OFS:   next_rdata[7:0] = een;
        default:   next_rdata = RDATA_ZERO;
      endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Descriptor table, deliberately without reset
  always_ff @(posedge mclk_i)
  begin
    if (wr_bdt)
      case (acc_addr[3:2])
        FLD_STAT: bd_stat[acc_bd] <= hwdata_i[7:0];
        FLD_CNT:  bd_cnt[acc_bd]  <= hwdata_i[7:0];
        FLD_ADRL: bd_adrl[acc_bd] <= hwdata_i[7:0];
        default:  bd_adrh[acc_bd] <= hwdata_i[7:0];
      endcase
    // Engine write-back wins over a same-cycle CPU write to that descriptor's status or count byte
    if (complete_c)
    begin
      bd_stat[idx_c] <= {1'b0, bd_stat[idx_c][TOGGLE_BIT],
                         eng_pid_i, eng_count_i[9:8]};
      bd_cnt[idx_c]  <= eng_count_i[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Config and ping-pong pointers
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      cfg <= CFG_RST;
    else if (wr_pend && (acc_addr == CFG_OFS))
      cfg <= hwdata_i[7:0];
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i || !mod_en || cfg[CFG_PTR_CLR_BIT])
    begin
      for (int i = 0; i < PTR_NUM; i++)
        ptr[i] <= 1'b0;
    end
    else if (complete_c && is_pp(mode, eng_ep_i, eng_dir_in_i))
      ptr[ptr_sel] <= ~cur_pp;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transfer status FIFO: entry is endpoint, direction, parity
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      fifo_wp  <= 2'h0;
      fifo_rp  <= 2'h0;
      fifo_cnt <= FIFO_EMPTY;
      // Cleared so a slot read before its first entry is written reads as zero rather than unknown
      for (int i = 0; i < FIFO_DEPTH; i++)
        tfifo[i] <= 6'h00;
    end
    else
    begin
      if (complete_c)
      begin
        tfifo[fifo_wp] <= {eng_ep_i, eng_dir_in_i, cur_pp};
        fifo_wp        <= fifo_wp + 2'h1;
      end
      if (trn_clr)
        fifo_rp <= fifo_rp + 2'h1;
      fifo_cnt <= fifo_cnt + {2'h0, complete_c} - {2'h0, trn_clr};
    end
  end

  // Completions wait while the FIFO is full so no entry is lost
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      eng_ready_o <= 1'b0;
    else
      eng_ready_o <= (fifo_cnt + {2'h0, complete_c}) < FIFO_FULL;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Engine lookup outputs
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      eng_bd_index_o  <= 6'h00;
      eng_bd_owned_o  <= 1'b0;
      eng_bd_toggle_o <= 1'b0;
      eng_bd_cfg_o    <= 4'h0;
      eng_bd_count_o  <= 10'h000;
      eng_bd_addr_o   <= 16'h0000;
    end
    else
    begin
      eng_bd_index_o  <= idx_c;
      eng_bd_owned_o  <= owned_c;
      eng_bd_toggle_o <= bd_stat[idx_c][TOGGLE_BIT];
      eng_bd_cfg_o    <= bd_stat[idx_c][CFGF_HI:CFGF_LO];
      eng_bd_count_o  <= {bd_stat[idx_c][1:0], bd_cnt[idx_c]};
      eng_bd_addr_o   <= {bd_adrh[idx_c], bd_adrl[idx_c]};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt flags and enables, kept apart and combined only in the error summary and the request
  assign err_sum     = |(eflag & een);
  assign status_view = {1'b0, sflag[SF_SOF], sflag[SF_STALL], sflag[SF_IDLE],
                        (fifo_cnt != FIFO_EMPTY), sflag[SF_ACTV], err_sum, sflag[SF_URST]};

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      sflag <= FLAG_RST;
    else
      // Hardware set wins over a same-cycle software clear
      sflag <= ((wr_pend && (acc_addr == SFLAG_OFS)) ?
                 hwdata_i[7:0] & SFLAG_WMASK : sflag & SFLAG_WMASK)
               | {1'b0, ev_sof_i, stall_hit_c, ev_idle_i, 1'b0, ev_actv_i, 1'b0, ev_urst_i};
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      eflag <= FLAG_RST;
    else if (wr_pend && (acc_addr == EFLAG_OFS))
      eflag <= (eflag & hwdata_i[7:0]) | ev_err_i;
    else
      eflag <= eflag | ev_err_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      sen <= FLAG_RST;
      een <= FLAG_RST;
    end
    else
    begin
      if (wr_pend && (acc_addr == SEN_OFS))
        sen <= hwdata_i[7:0] & SFLAG_WMASK | 8'h0A & hwdata_i[7:0];
      if (wr_pend && (acc_addr == EEN_OFS))
        een <= hwdata_i[7:0];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      usb_irq_request_o <= 1'b0;
    else
      usb_irq_request_o <= |(status_view & sen);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_release;
    @(posedge mclk_i) disable iff (srst_i)
    complete_c |=> !bd_stat[$past(idx_c)][OWN_BIT];
  endproperty
  a_release: assert property (p_release) else $error("owned bit not cleared");

  property p_keep_toggle;
    @(posedge mclk_i) disable iff (srst_i)
    complete_c |=> bd_stat[$past(idx_c)][TOGGLE_BIT] == $past(bd_stat[idx_c][TOGGLE_BIT]);
  endproperty
  a_keep_toggle: assert property (p_keep_toggle) else $error("bit 6 altered");

  property p_pid;
    @(posedge mclk_i) disable iff (srst_i)
    complete_c |=> bd_stat[$past(idx_c)][CFGF_HI:CFGF_LO] == $past(eng_pid_i);
  endproperty
  a_pid: assert property (p_pid) else $error("pid not written");

  property p_count;
    @(posedge mclk_i) disable iff (srst_i)
    complete_c |=> {bd_stat[$past(idx_c)][1:0], bd_cnt[$past(idx_c)]} == $past(eng_count_i);
  endproperty
  a_count: assert property (p_count) else $error("count not written");

  property p_flip;
    @(posedge mclk_i) disable iff (srst_i || cfg[CFG_PTR_CLR_BIT] || !mod_en)
    complete_c && is_pp(mode, eng_ep_i, eng_dir_in_i) |=> ptr[$past(ptr_sel)] != $past(cur_pp);
  endproperty
  a_flip: assert property (p_flip) else $error("pointer not flipped");

  property p_ptr_clear;
    @(posedge mclk_i) disable iff (srst_i)
    cfg[CFG_PTR_CLR_BIT] |=> !cur_pp;
  endproperty
  a_ptr_clear: assert property (p_ptr_clear) else $error("pointer not even");

  property p_map_none;
    @(posedge mclk_i) disable iff (srst_i)
    mode == PP_NONE |-> idx_c == {eng_ep_i, eng_dir_in_i} + {eng_ep_i, 1'b0} - {eng_ep_i, 1'b0};
  endproperty
  a_map_none: assert property (p_map_none) else $error("mode 0 map wrong");

  property p_irq;
    @(posedge mclk_i) disable iff (srst_i)
    ##1 usb_irq_request_o == $past(|(status_view & sen));
  endproperty
  a_irq: assert property (p_irq) else $error("irq not merged");

  property p_err_sum;
    @(posedge mclk_i) disable iff (srst_i)
    |(ev_err_i & een) |=> status_view[SF_ERR];
  endproperty
  a_err_sum: assert property (p_err_sum) else $error("error summary missing");

  property p_pop;
    @(posedge mclk_i) disable iff (srst_i)
    trn_clr && !complete_c |=> fifo_cnt == $past(fifo_cnt) - 3'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("fifo not advanced");

  c_writeback: cover property (@(posedge mclk_i) disable iff (srst_i) complete_c);
  c_pp_odd:    cover property (@(posedge mclk_i) disable iff (srst_i) complete_c && cur_pp);
  c_irq:       cover property (@(posedge mclk_i) disable iff (srst_i) usb_irq_request_o);
  c_stall:     cover property (@(posedge mclk_i) disable iff (srst_i) stall_hit_c);

endmodule : udp_core
`default_nettype wire

// ### sim/udp_eng_model.sv
`timescale 1ns/100ps
`default_nettype none
module udp_eng_model
(
  // Clock and handshake
  input  wire logic       mclk_i,
  input  wire logic       ready_i,
  // Token and completion
  output logic      [3:0] ep_o,
  output logic            dir_in_o,
  output logic            done_o,
  output logic      [3:0] pid_o,
  output logic      [9:0] count_o
);
  initial
  begin
    ep_o = 4'h0;
    dir_in_o = 1'h0;
    done_o = 1'h0;
    pid_o = 4'h0;
    count_o = 10'h000;
  end

  ////////////////////////////////////////
  task automatic point(input logic [3:0] e, input logic d);
    ep_o <= e;
    dir_in_o <= d;
  endtask : point

  // Done is held until ready is seen, so a full status queue only delays it
  task automatic xfer(input logic [3:0] e, input logic d, input logic [3:0] p, input logic [9:0] c);
    point(e, d);
    pid_o <= p;
    count_o <= c;
    done_o <= 1'h1;
    @(negedge mclk_i);
    while (ready_i !== 1'h1)
      @(negedge mclk_i);
    @(posedge mclk_i);
    done_o <= 1'h0;
    // Released lines show the inverse so stale values never look valid
    pid_o <= ~p;
    count_o <= ~c;
  endtask : xfer
endmodule : udp_eng_model
`default_nettype wire

// ### sim/usb_descriptor_pingpong_irq_test.sv
`timescale 1ns/100ps
`default_nettype none
module usb_descriptor_pingpong_irq_test
  import udp_pkg::*;
;
  logic        mclk_i;
  logic        srst_i;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic [1:0]  hresp;
  logic [3:0]  ep;
  logic        dir_in;
  logic        done;
  logic [3:0]  pid;
  logic [9:0]  cnt;
  logic        eng_rdy;
  logic [5:0]  bd_idx;
  logic        bd_own;
  logic [15:0] bd_addr;
  logic [3:0]  ev;
  logic [7:0]  err;
  logic        irq;
  logic [31:0] rd_q;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // Rows: mode, endpoint, direction, expected descriptor index
  logic [12:0] rows [9] = '{{2'h0, 4'h0, 1'h0, 6'h00}, {2'h0, 4'hF, 1'h1, 6'h1F},
    {2'h1, 4'h0, 1'h0, 6'h00}, {2'h1, 4'h0, 1'h1, 6'h02}, {2'h1, 4'hF, 1'h0, 6'h1F},
    {2'h1, 4'hF, 1'h1, 6'h20}, {2'h2, 4'h1, 1'h1, 6'h06}, {2'h2, 4'hF, 1'h1, 6'h3E},
    {2'h3, 4'h1, 1'h1, 6'h03}};
  logic [31:0] stop_cfg [2] = '{32'h1A, 32'h02};

  ////////////////////////////////////////
  udp_core DUT (
    .mclk_i, .srst_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .eng_ep_i(ep), .eng_dir_in_i(dir_in), .eng_done_i(done), .eng_pid_i(pid),
    .eng_count_i(cnt), .eng_ready_o(eng_rdy), .eng_bd_index_o(bd_idx), .eng_bd_owned_o(bd_own),
    .eng_bd_toggle_o(), .eng_bd_cfg_o(), .eng_bd_count_o(), .eng_bd_addr_o(bd_addr),
    .ev_sof_i(ev[3]), .ev_idle_i(ev[2]), .ev_actv_i(ev[1]), .ev_urst_i(ev[0]), .ev_err_i(err),
    .usb_irq_request_o(irq));

  udp_eng_model eng (.mclk_i(mclk_i), .ready_i(eng_rdy), .ep_o(ep), .dir_in_o(dir_in),
    .done_o(done), .pid_o(pid), .count_o(cnt));

  ////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
      miscompares++;
    if (g !== e)
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
  endtask : chk

  task automatic rdy;
    @(negedge mclk_i);
    while (hready !== 1'h1)
      @(negedge mclk_i);
    rd_q = hrdata;
    @(posedge mclk_i);
  endtask : rdy

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask : wr

  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rd_q, e);
  endtask : rc

  task automatic lk(input logic [5:0] e);
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk({26'h0, bd_idx}, {26'h0, e});
    @(posedge mclk_i);
  endtask : lk

  ////////////////////////////////////////
  initial
  begin
    mclk_i = 1'h0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Test time is a few hundred cycles; the ceiling leaves ample margin
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end

  initial
  begin
    srst_i = 1'h1;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ev = 4'h0;
    err = 8'h00;
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'h0;
    repeat (2) @(posedge mclk_i);
    foreach (rows[i])
    begin
      wr(32'h400, {24'h0, 6'h02, rows[i][12:11]});
      eng.point(rows[i][10:7], rows[i][6]);
      lk(rows[i][5:0]);
    end
    $display("test mapping done");
    srst_i <= 1'h1;
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h0);
    srst_i <= 1'h0;
    repeat (2) @(posedge mclk_i);
    for (int a = 0; a < 6; a++)
      rc(32'h400 + 32'(4 * a), 32'h0);
    rc(32'h800, 32'h0);
    chk({30'h0, hresp}, {30'h0, HRESP_OKAY});
    wr(32'h3FC, 32'h7F);
    rc(32'h3FC, 32'h7F);
    $display("test reset done");
    wr(32'h400, 32'h0A);
    wr(32'h40C, 32'h08);
    wr(32'h48, 32'h34);
    wr(32'h4C, 32'h04);
    wr(32'h40, 32'hC0);
    eng.point(4'h1, 1'h0);
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk({16'h0, bd_addr}, 32'h0434);
    chk({31'h0, bd_own}, 32'h1);
    eng.xfer(4'h1, 1'h0, 4'h1, 10'h2A5);
    rc(32'h40, 32'h46);
    rc(32'h44, 32'hA5);
    rc(32'h408, 32'h08);
    chk({31'h0, irq}, 32'h1);
    lk(6'h05);
    wr(32'h50, 32'h80);
    eng.xfer(4'h1, 1'h0, 4'h1, 10'h003);
    rc(32'h50, 32'h04);
    rc(32'h404, 32'h08);
    wr(32'h408, 32'h0);
    rc(32'h404, 32'h0A);
    lk(6'h04);
    wr(32'h408, 32'h0);
    rc(32'h408, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test write-back done");
    wr(32'h60, 32'hA0);
    eng.xfer(4'h1, 1'h1, 4'h9, 10'h010);
    rc(32'h60, 32'hA0);
    rc(32'h408, 32'h0);
    wr(32'h60, 32'h84);
    eng.xfer(4'h1, 1'h1, 4'h9, 10'h010);
    rc(32'h60, 32'h84);
    rc(32'h408, 32'h20);
    eng.xfer(4'h1, 1'h1, PID_SETUP, 10'h001);
    rc(32'h60, 32'h34);
    rc(32'h404, 32'h0C);
    wr(32'h408, 32'h0);
    eng.xfer(4'h1, 1'h0, 4'h1, 10'h000);
    rc(32'h408, 32'h0);
    $display("test keep and stall done");
    foreach (stop_cfg[k])
    begin
      wr(32'h40, 32'h80);
      eng.xfer(4'h1, 1'h0, 4'h1, 10'h000);
      lk(6'h05);
      wr(32'h400, stop_cfg[k]);
      lk(6'h04);
      wr(32'h400, 32'h0A);
      wr(32'h408, 32'h0);
    end
    $display("test pointer clear done");
    ev <= 4'hF;
    @(posedge mclk_i);
    ev <= 4'h0;
    rc(32'h408, 32'h55);
    chk({31'h0, irq}, 32'h0);
    wr(32'h408, 32'h0);
    rc(32'h408, 32'h0);
    err <= 8'h01;
    @(posedge mclk_i);
    err <= 8'h00;
    rc(32'h410, 32'h01);
    rc(32'h408, 32'h0);
    wr(32'h414, 32'h01);
    wr(32'h40C, 32'h02);
    rc(32'h408, 32'h02);
    chk({31'h0, irq}, 32'h1);
    wr(32'h410, 32'h0);
    rc(32'h408, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupts done");
    end_sim();
  end
endmodule : usb_descriptor_pingpong_irq_test
`default_nettype wire
